//--- test/odt_ctl_model.sv
// Purpose: controller model that drives the start contact
// Assumes: want_in changes just after a clock edge
// Notes:   start is a plain level with no released state
`timescale 1ns/1ps
module odt_ctl_model (
  input  wire  clk_in,
  input  wire  want_in,
  output logic start_out
);
  initial start_out = 1'b0;
  // one register stage, like a controller scan output
  always @(posedge clk_in) start_out <= want_in;
endmodule // odt_ctl_model

//--- test/odt_on_delay_timer_asserts.sv
// Purpose: port checks for the on-delay timer
// Assumes: tick period of at least 5 cycles
// Notes:   register contents are left to the bench
`timescale 1ns/1ps
module odt_chk (
  input wire        SYS_CLK_IN,
  input wire        ARST_N_IN,
  input wire        START_IN,
  input wire        DONE_OUT,
  input wire [15:0] ELAPSED_OUT,
  input wire        S_AXI_ARVALID_IN,
  input wire        S_AXI_ARREADY_OUT,
  input wire        S_AXI_RVALID_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  a_clear_low: assert property (
    !START_IN [*3] |=> ELAPSED_OUT == 16'h0 && !DONE_OUT)
    else $error("count or done not cleared");
  a_done_zero: assert property (
    DONE_OUT |-> ELAPSED_OUT == 16'h0) else $error("done with count left");
  a_done_rise: assert property (
    $rose(DONE_OUT) |-> $past(ELAPSED_OUT) == 16'h0)
    else $error("done rose early");
  a_hold_zero: assert property (
    START_IN [*4] ##0 DONE_OUT |=> DONE_OUT && ELAPSED_OUT == 16'h0)
    else $error("done not held");
  a_step_one: assert property (
    START_IN [*4] ##0 ELAPSED_OUT != 16'h0 |=> $stable(ELAPSED_OUT)
    || ELAPSED_OUT == $past(ELAPSED_OUT) - 16'h1) else $error("count jumped");
  // falling start clears to zero, so zero is allowed inside the gap
  a_tick_gap: assert property (
    START_IN && $past(ELAPSED_OUT) != 16'h0
    && ELAPSED_OUT == $past(ELAPSED_OUT) - 16'h1
    |=> ($stable(ELAPSED_OUT) || ELAPSED_OUT == 16'h0) [*4])
    else $error("ticks too close");
  a_read_lat: assert property (
    S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
    else $error("read answer late");
  a_read_block: assert property (
    S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT) else $error("second read taken");
endmodule // odt_chk
bind odt_on_delay_timer odt_chk u_chk (.SYS_CLK_IN(SYS_CLK_IN),
  .ARST_N_IN(ARST_N_IN), .START_IN(START_IN), .DONE_OUT(DONE_OUT),
  .ELAPSED_OUT(ELAPSED_OUT), .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN),
  .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT),
  .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT));

//--- test/test_on_delay_timer.sv
// Purpose: self-checking bench for the on-delay timer
// Assumes: tick counts shortened to 5 and 20 cycles
// Notes:   start comes from the controller model
`timescale 1ns/1ps
`include "odt_map.vh"
module test_on_delay_timer;
  logic        clk = 0, rst_n = 0, want = 0, done, irq, start;
  logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic        awr, wrr, bv, arr, rv;
  logic [1:0]  bresp, rresp, lb;
  logic [4:0]  awa = 0, ara = 0;
  logic [15:0] el;
  logic [31:0] wd = 0, rdat;
  int          n_mismatch = 0, checks = 0, n;
  always #20 clk = ~clk;
  odt_ctl_model u_ctl (.clk_in(clk), .want_in(want), .start_out(start));
  odt_on_delay_timer #(.CENTI_CYCLES(5), .DECI_CYCLES(20)) u_dut (
    .SYS_CLK_IN(clk), .ARST_N_IN(rst_n), .START_IN(start),
    .DONE_OUT(done), .ELAPSED_OUT(el), .IRQ_OUT(irq),
    .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF),
    .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrr), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br), .S_AXI_ARADDR_IN(ara),
    .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
    .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr));
  task automatic wrap_up;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic quit;
    n_mismatch++;
    wrap_up();
  endtask
  task automatic wr(logic [4:0] a, logic [31:0] d);
    int i;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    br <= 1;
    for (i = 0; i < 50 && bv !== 1'b1; i++) begin
      @(posedge clk);
      if (awr === 1'b1) awv <= 0;
      if (wrr === 1'b1) wv <= 0;
    end
    br <= 0;
    lb = bresp;
    if (bv !== 1'b1) quit();
  endtask
  task automatic rc(string nm, logic [4:0] a, logic [31:0] e, logic [1:0] r);
    int i;
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rr <= 1;
    for (i = 0; i < 50 && rv !== 1'b1; i++) begin
      @(posedge clk);
      if (arr === 1'b1) arv <= 0;
    end
    rr <= 0;
    if (rv !== 1'b1) quit();
    chk(nm, e, rdat);
    chk("rresp", {30'h0, r}, {30'h0, rresp});
  endtask
  // counts edges until the timer shows the wanted state
  task automatic wt(logic [15:0] v, logic d);
    for (n = 0; n < 200 && !(el === v && done === d); n++) begin
      @(posedge clk);
      #1;
    end
    if (n >= 200) quit();
  endtask
  task automatic go(logic v);
    @(posedge clk);
    want <= v;
  endtask
  task automatic ci(logic e);
    repeat (3) @(posedge clk);
    #1;
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    rc("preset", `ODT_REG_PRESET, 32'h0, `ODT_RESP_OKAY);
    rc("config", `ODT_REG_CONFIG, 32'h0, `ODT_RESP_OKAY);
    rc("hole", 5'h1C, 32'h0, `ODT_RESP_DECERR);
    wr(5'h1C, 32'hFFFF);
    chk("bresp", {30'h0, `ODT_RESP_DECERR}, {30'h0, lb});
    $display("test registers done");
    wr(`ODT_REG_PRESET, 32'h3);
    wr(`ODT_REG_IRQ_ENABLE, 32'h1);
    go(1);
    wt(16'h3, 0);
    wt(16'h2, 0);
    chk("centi tick", 5, n);
    wt(16'h0, 1);
    chk("done delay", 11, n);
    ci(1);
    repeat (20) @(posedge clk);
    #1;
    chk("held", 32'h10000, {15'h0, done, el});
    rc("elapsed", `ODT_REG_ELAPSED, 32'h0, `ODT_RESP_OKAY);
    rc("state", `ODT_REG_STATE, 32'h7, `ODT_RESP_OKAY);
    rc("status", `ODT_REG_IRQ_STATUS, 32'h3, `ODT_RESP_OKAY);
    wr(`ODT_REG_IRQ_ENABLE, 32'h0);
    ci(0);
    wr(`ODT_REG_IRQ_CLEAR, 32'h3);
    rc("cleared", `ODT_REG_IRQ_STATUS, 32'h0, `ODT_RESP_OKAY);
    go(0);
    wt(16'h0, 0);
    chk("clear", 4, n);
    wr(`ODT_REG_PRESET, 32'h0);
    go(1);
    wt(16'h0, 1);
    chk("zero preset", 5, n);
    go(0);
    wt(16'h0, 0);
    $display("test centi done");
    wr(`ODT_REG_CONFIG, 32'h1);
    wr(`ODT_REG_PRESET, 32'h7FFF);
    go(1);
    wt(16'h7FFF, 0);
    wt(16'h7FFE, 0);
    chk("deci tick", 20, n);
    go(0);
    wt(16'h0, 0);
    chk("abort", 4, n);
    $display("test deci done");
    wrap_up();
  end
endmodule // test_on_delay_timer

//--- verilog/odt_map.vh
// Purpose: constants for the on-delay timer: offsets, fields, resets, timing
// Assumes: 25 MHz system clock
// Notes:   byte addresses on a 32-bit AXI4-Lite register bus
`ifndef ODT_MAP_VH
`define ODT_MAP_VH

`define ODT_CLK_PERIOD_NS   40
`define ODT_CENTI_TICK_NS   10000000
`define ODT_DECI_TICK_NS    100000000
`define ODT_CENTI_CYCLES    (`ODT_CENTI_TICK_NS / `ODT_CLK_PERIOD_NS)
`define ODT_DECI_CYCLES     (`ODT_DECI_TICK_NS / `ODT_CLK_PERIOD_NS)
`define ODT_DIV_W           22

`define ODT_ADDR_W          5
`define ODT_REG_PRESET      5'h00
`define ODT_REG_CONFIG      5'h04
`define ODT_REG_STATE       5'h08
`define ODT_REG_ELAPSED     5'h0C
`define ODT_REG_IRQ_STATUS  5'h10
`define ODT_REG_IRQ_CLEAR   5'h14
`define ODT_REG_IRQ_ENABLE  5'h18

`define ODT_CFG_DECI_BIT    0
`define ODT_ST_DONE_BIT     0
`define ODT_ST_RUN_BIT      1
`define ODT_ST_START_BIT    2
`define ODT_IRQ_DONE_BIT    0
`define ODT_IRQ_START_BIT   1
`define ODT_IRQ_W           2

`define ODT_COUNT_W         16
`define ODT_PRESET_RESET    16'h0000
`define ODT_CONFIG_RESET    1'b0
`define ODT_IRQ_EN_RESET    2'h0

`define ODT_RESP_OKAY       2'b00
`define ODT_RESP_DECERR     2'b11

`endif

//--- verilog/odt_on_delay_timer.v
// Purpose: on-delay timer with 10 ms or 100 ms tick, AXI4-Lite registers
// Assumes: START_IN is asynchronous to SYS_CLK_IN
// Notes:   start is seen two cycles late through its synchroniser
//
// Function
// - start rising edge loads preset, begins timing
// - centisecond variant: decrement once per 10 ms
// - done asserts when elapsed count reaches zero
// - start low: count zero, done low
// - decisecond variant covers up to 6553.5 s
// - on-delay: done only after full preset
// - decisecond variant: decrement once per 100 ms
`timescale 1ns/1ps
`include "odt_map.vh"
module odt_on_delay_timer #(
  parameter CENTI_CYCLES = `ODT_CENTI_CYCLES,
  parameter DECI_CYCLES  = `ODT_DECI_CYCLES
) (
  input  wire                    SYS_CLK_IN,
  input  wire                    ARST_N_IN,
  input  wire                    START_IN,
  output reg                     DONE_OUT,
  output reg  [`ODT_COUNT_W-1:0] ELAPSED_OUT,
  output reg                     IRQ_OUT,
  input  wire [`ODT_ADDR_W-1:0]  S_AXI_AWADDR_IN,
  input  wire                    S_AXI_AWVALID_IN,
  output reg                     S_AXI_AWREADY_OUT,
  input  wire [31:0]             S_AXI_WDATA_IN,
  input  wire [3:0]              S_AXI_WSTRB_IN,
  input  wire                    S_AXI_WVALID_IN,
  output reg                     S_AXI_WREADY_OUT,
  output reg  [1:0]              S_AXI_BRESP_OUT,
  output reg                     S_AXI_BVALID_OUT,
  input  wire                    S_AXI_BREADY_IN,
  input  wire [`ODT_ADDR_W-1:0]  S_AXI_ARADDR_IN,
  input  wire                    S_AXI_ARVALID_IN,
  output reg                     S_AXI_ARREADY_OUT,
  output reg  [31:0]             S_AXI_RDATA_OUT,
  output reg  [1:0]              S_AXI_RRESP_OUT,
  output reg                     S_AXI_RVALID_OUT,
  input  wire                    S_AXI_RREADY_IN
);
  localparam CW = `ODT_COUNT_W;
  localparam IW = `ODT_IRQ_W;

  reg  [CW-1:0]          preset_value;
  reg                    cfg_deci;
  reg  [IW-1:0]          irq_status;
  reg  [IW-1:0]          irq_enable;
  reg                    start_meta;
  reg                    start_sync;
  reg                    start_prev;
  reg                    running;
  reg  [`ODT_ADDR_W-1:0] aw_addr;
  reg                    aw_have;
  reg  [31:0]            w_data;
  reg  [3:0]             w_strb;
  reg                    w_have;
  wire                   tick;
  wire                   start_rise = start_sync & ~start_prev;
  wire                   wr_go = aw_have & w_have & ~S_AXI_BVALID_OUT;
  wire                   done_rise;
  wire [IW-1:0]          irq_events;
  wire [IW-1:0]          irq_clear;

  // start comes from a pin: two flops before anything reads it
  always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      start_meta <= 1'b0;
      start_sync <= 1'b0;
      start_prev <= 1'b0;
    end else begin
      start_meta <= START_IN;
      start_sync <= start_meta;
      start_prev <= start_sync;
    end
  end

  // divider restarts on each new start so the first tick is a full period
  odt_tick_div #(
    .W          (`ODT_DIV_W),
    .FAST_COUNT (CENTI_CYCLES),
    .SLOW_COUNT (DECI_CYCLES)
  ) u_tick (
    .clk_in     (SYS_CLK_IN),
    .arst_n_in  (ARST_N_IN),
    .restart_in (start_rise | ~start_sync),
    .slow_in    (cfg_deci),
    .tick_out   (tick)
  );

  always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ELAPSED_OUT <= {CW{1'b0}};
      DONE_OUT    <= 1'b0;
      running     <= 1'b0;
    end else if (!start_sync) begin
      ELAPSED_OUT <= {CW{1'b0}};
      DONE_OUT    <= 1'b0;
      running     <= 1'b0;
    end else if (start_rise) begin
      ELAPSED_OUT <= preset_value;
      DONE_OUT    <= 1'b0;
      running     <= 1'b1;
    end else if (running) begin
      if (tick && ELAPSED_OUT != {CW{1'b0}})
        ELAPSED_OUT <= ELAPSED_OUT - {{(CW-1){1'b0}}, 1'b1};
      // zero is held, never wrapped
      DONE_OUT <= (ELAPSED_OUT == {CW{1'b0}});
    end
  end

  // done event taken from the count at zero before the done register sets, start event from the sync edge
  assign done_rise  = running & start_sync & ~start_rise & ~DONE_OUT &
                      (ELAPSED_OUT == {CW{1'b0}});
  assign irq_events = {start_rise, done_rise};
  assign irq_clear  = (wr_go && aw_addr == `ODT_REG_IRQ_CLEAR) ?
                      w_data[IW-1:0] : {IW{1'b0}};

  always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      irq_status <= {IW{1'b0}};
      IRQ_OUT    <= 1'b0;
    end else begin
      // a new event wins over a clear in the same cycle
      irq_status <= (irq_status & ~irq_clear) | irq_events;
      IRQ_OUT    <= |(((irq_status & ~irq_clear) | irq_events) & irq_enable);
    end
  end

  // write channel: address and data accepted in either order
  always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      S_AXI_AWREADY_OUT <= 1'b1;
      S_AXI_WREADY_OUT  <= 1'b1;
      S_AXI_BVALID_OUT  <= 1'b0;
      S_AXI_BRESP_OUT   <= `ODT_RESP_OKAY;
      aw_have           <= 1'b0;
      w_have            <= 1'b0;
      aw_addr           <= {`ODT_ADDR_W{1'b0}};
      w_data            <= 32'h00000000;
      w_strb            <= 4'h0;
      preset_value      <= `ODT_PRESET_RESET;
      cfg_deci          <= `ODT_CONFIG_RESET;
      irq_enable        <= `ODT_IRQ_EN_RESET;
    end else begin
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
        aw_addr           <= S_AXI_AWADDR_IN;
        aw_have           <= 1'b1;
        S_AXI_AWREADY_OUT <= 1'b0;
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
        w_data           <= S_AXI_WDATA_IN;
        w_strb           <= S_AXI_WSTRB_IN;
        w_have           <= 1'b1;
        S_AXI_WREADY_OUT <= 1'b0;
      end
      if (wr_go) begin
        aw_have          <= 1'b0;
        w_have           <= 1'b0;
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT  <= `ODT_RESP_OKAY;
        case (aw_addr)
          `ODT_REG_PRESET: begin
            if (w_strb[0])
              preset_value[7:0] <= w_data[7:0];
            if (w_strb[1])
              preset_value[15:8] <= w_data[15:8];
          end
          `ODT_REG_CONFIG: begin
            if (w_strb[0])
              cfg_deci <= w_data[`ODT_CFG_DECI_BIT];
          end
          `ODT_REG_IRQ_ENABLE: begin
            if (w_strb[0])
              irq_enable <= w_data[IW-1:0];
          end
          `ODT_REG_STATE, `ODT_REG_ELAPSED, `ODT_REG_IRQ_STATUS,
          `ODT_REG_IRQ_CLEAR: begin
            S_AXI_BRESP_OUT <= `ODT_RESP_OKAY;
          end
          default: begin
            S_AXI_BRESP_OUT <= `ODT_RESP_DECERR;
          end
        endcase
      end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
        S_AXI_BVALID_OUT  <= 1'b0;
        S_AXI_AWREADY_OUT <= 1'b1;
        S_AXI_WREADY_OUT  <= 1'b1;
      end
    end
  end

  // read channel: one outstanding read, answer one edge after acceptance
  always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      S_AXI_ARREADY_OUT <= 1'b1;
      S_AXI_RVALID_OUT  <= 1'b0;
      S_AXI_RDATA_OUT   <= 32'h00000000;
      S_AXI_RRESP_OUT   <= `ODT_RESP_OKAY;
    end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
      S_AXI_ARREADY_OUT <= 1'b0;
      S_AXI_RVALID_OUT  <= 1'b1;
      S_AXI_RRESP_OUT   <= `ODT_RESP_OKAY;
      S_AXI_RDATA_OUT   <= 32'h00000000;
      case (S_AXI_ARADDR_IN)
        `ODT_REG_PRESET:
          S_AXI_RDATA_OUT[CW-1:0] <= preset_value;
        `ODT_REG_CONFIG:
          S_AXI_RDATA_OUT[`ODT_CFG_DECI_BIT] <= cfg_deci;
        `ODT_REG_STATE: begin
          S_AXI_RDATA_OUT[`ODT_ST_DONE_BIT]  <= DONE_OUT;
          S_AXI_RDATA_OUT[`ODT_ST_RUN_BIT]   <= running;
          S_AXI_RDATA_OUT[`ODT_ST_START_BIT] <= start_sync;
        end
        `ODT_REG_ELAPSED:
          S_AXI_RDATA_OUT[CW-1:0] <= ELAPSED_OUT;
        `ODT_REG_IRQ_STATUS:
          S_AXI_RDATA_OUT[IW-1:0] <= irq_status;
        `ODT_REG_IRQ_ENABLE:
          S_AXI_RDATA_OUT[IW-1:0] <= irq_enable;
        `ODT_REG_IRQ_CLEAR:
          S_AXI_RDATA_OUT <= 32'h00000000; // write-only, reads zero
        default:
          S_AXI_RRESP_OUT <= `ODT_RESP_DECERR;
      endcase
    end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
      S_AXI_RVALID_OUT  <= 1'b0;
      S_AXI_ARREADY_OUT <= 1'b1;
    end
  end
endmodule // odt_on_delay_timer

//--- verilog/odt_tick_div.v
// Purpose: tick strobe divider with two selectable periods
// Assumes: restart is a same-clock level or pulse
// Notes:   tick is one cycle wide, first tick one full period after restart
`timescale 1ns/1ps
module odt_tick_div #(
  parameter W          = 22,
  parameter FAST_COUNT = 250000,
  parameter SLOW_COUNT = 2500000
) (
  input  wire         clk_in,
  input  wire         arst_n_in,
  input  wire         restart_in,
  input  wire         slow_in,
  output reg          tick_out
);
  reg  [W-1:0] count;
  wire [W-1:0] last = slow_in ? SLOW_COUNT[W-1:0] - {{(W-1){1'b0}}, 1'b1}
                              : FAST_COUNT[W-1:0] - {{(W-1){1'b0}}, 1'b1};

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count    <= {W{1'b0}};
      tick_out <= 1'b0;
    end else if (restart_in) begin
      // parks at one: the registered tick already costs a cycle
      count    <= {{(W-1){1'b0}}, 1'b1};
      tick_out <= 1'b0;
    end else if (count >= last) begin
      // >= so a switch to the short period mid-count cannot overrun
      count    <= {W{1'b0}};
      tick_out <= 1'b1;
    end else begin
      count    <= count + {{(W-1){1'b0}}, 1'b1};
      tick_out <= 1'b0;
    end
  end
endmodule // odt_tick_div
